// ==== inc/aic_map.svh ====
// Register map, field positions and timing constants of the analog input
// channel control block. Assumes a 50 MHz core clock.
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define AIC_REG_CTRL 8'h00
`define AIC_REG_MODE_LO 8'h04
`define AIC_REG_MODE_HI 8'h08
`define AIC_REG_AVG_LEN 8'h0c
`define AIC_REG_RANGE_ALARM 8'h10
`define AIC_REG_IRQ_EN 8'h14
`define AIC_REG_WARN_LED 8'h18
`define AIC_REG_STATUS 8'h1c
`define AIC_REG_RESULT_BASE 8'h20
`define AIC_REG_RESULT_END 8'h60

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define AIC_CTRL_RUN_BIT 0
`define AIC_DETECT_LSB 0
`define AIC_ALARM_LSB 8
`define AIC_SUPPLY_BIT 15
`define AIC_CHANNELS 8
`define AIC_MODE_W 4
`define AIC_RST_WORD16 16'h0000
`define AIC_RST_MODES 32'h0000_0000
`define AIC_RST_AVG_LEN 7'h01

// ------------------------------------------------------------
// Input mode codes
// ------------------------------------------------------------
`define AIC_MODE_OFF 4'h0
`define AIC_MODE_V_LAST 4'h5
`define AIC_MODE_I_LAST 4'h8
`define AIC_MODE_1V_5V 4'h5
`define AIC_MODE_4MA_20MA 4'h7
`define AIC_MODE_CO_LAST 4'h3
`define AIC_MODE_CO_4MA_20MA 4'h2

// ------------------------------------------------------------
// Averaging and timing
// ------------------------------------------------------------
`define AIC_AVG_MAX 7'd100
`define AIC_CLK_MHZ 50
`define AIC_CONV_TIME_US 150
`define AIC_BLINK_HALF_MS 500
`define AIC_FLOAT_BIAS 8'd127
`define AIC_FLOAT_MANT_TOP 5'd23

`endif

// ==== inc/aic_pkg.sv ====
// Types shared by the analog input channel control design.
// Assumes the map header supplies all numeric constants.
package aic_pkg;
	typedef enum {SCAN_IDLE, SCAN_DWELL, SCAN_STORE} scan_state_e;
	typedef logic [3:0] mode_t;
	typedef logic [15:0] word_t;
endpackage

// ==== logic/channel_averager.sv ====
// Moving-window averager shared by all eight channels.
// Assumes samples arrive one at a time, tagged with their channel.
`timescale 1ns/10ps
`default_nettype none
`include "aic_map.svh"

module channel_averager (
	input wire logic mclk, // Core clock
	input wire logic reset, // Synchronous reset, high
	input wire logic sampleValid, // New sample this cycle
	input wire logic [2:0] sampleChan, // Channel of the sample
	input wire logic signed [15:0] sample, // Raw converted value
	input wire logic [6:0] winLen, // Window length, 1 to 100
	output logic avgValid, // Average ready, one cycle
	output logic [2:0] avgChan, // Channel of the average
	output logic signed [15:0] avg // Averaged value
);
	logic signed [15:0] hist [0:`AIC_CHANNELS*`AIC_AVG_MAX-1];
	logic signed [23:0] sum [0:`AIC_CHANNELS-1];
	logic [6:0] fill [0:`AIC_CHANNELS-1];
	logic [6:0] ptr [0:`AIC_CHANNELS-1];
	logic [6:0] lastLen;
	logic [6:0] len, baseFill, basePtr, next_fill, next_ptr;
	logic signed [23:0] baseSum, next_sum, quotient;
	logic [9:0] slot;
	logic flush;

	always_comb begin
		len = (winLen == 7'h0) ? 7'h1 : ((winLen > `AIC_AVG_MAX) ? `AIC_AVG_MAX : winLen);
		// New length restarts every window; stale slots would skew the sum
		flush = (len != lastLen);
		baseFill = flush ? 7'h0 : fill[sampleChan];
		basePtr = flush ? 7'h0 : ptr[sampleChan];
		baseSum = flush ? 24'sh0 : sum[sampleChan];
		slot = 10'(sampleChan) * 10'(`AIC_AVG_MAX) + 10'(basePtr);
		if (baseFill < len) begin
			next_sum = baseSum + 24'(sample);
			next_fill = baseFill + 7'h1;
		end else begin
			next_sum = baseSum + 24'(sample) - 24'(hist[slot]);
			next_fill = baseFill;
		end
		next_ptr = (basePtr + 7'h1 >= len) ? 7'h0 : basePtr + 7'h1;
		quotient = next_sum / $signed({17'h0, next_fill});
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			avgValid <= 1'b0;
			avgChan <= 3'h0;
			avg <= 16'sh0;
			lastLen <= `AIC_RST_AVG_LEN;
			for (int i = 0; i < `AIC_CHANNELS; i++) begin
				sum[i] <= 24'sh0;
				fill[i] <= 7'h0;
				ptr[i] <= 7'h0;
			end
		end else begin
			avgValid <= sampleValid;
			if (sampleValid) begin
				if (flush) begin
					for (int i = 0; i < `AIC_CHANNELS; i++) begin
						sum[i] <= 24'sh0;
						fill[i] <= 7'h0;
						ptr[i] <= 7'h0;
					end
				end
				sum[sampleChan] <= next_sum;
				fill[sampleChan] <= next_fill;
				ptr[sampleChan] <= next_ptr;
				hist[slot] <= sample;
				lastLen <= len;
				avgChan <= sampleChan;
				avg <= quotient[15:0];
			end
		end
	end

	chk_window_bound:
	assert property (@(posedge mclk) disable iff (reset) sampleValid |=> fill[avgChan] <= lastLen)
		else $error("averaging window holds more samples than its length");
endmodule
`default_nettype wire

// ==== logic/analog_input_channel_control.sv ====
// Channel configuration, scan, status and indicator logic of an eight
// channel analog input module, reached over an AHB-Lite slave port.
// Assumes a single AHB master, word transfers only, and a front end that
// holds adcData valid for convChannel while the dwell runs.
`timescale 1ns/10ps
`default_nettype none
`include "aic_map.svh"

module analog_input_channel_control #(
	parameter int CONV_CYCLES = `AIC_CONV_TIME_US * `AIC_CLK_MHZ, // Dwell per channel
	parameter int BLINK_CYCLES = `AIC_BLINK_HALF_MS * 1000 * `AIC_CLK_MHZ // Half blink period
) (
	input wire logic mclk, // Core clock, 50 MHz
	input wire logic reset, // Synchronous reset, high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	output logic [31:0] hrdata, // AHB read data
	input wire logic currentOnly, // Current-only variant
	input wire logic cpuRunning, // Host CPU in run state
	input wire logic signed [15:0] adcData, // Converted sample
	input wire logic [7:0] rangeExceeded, // Input beyond hardware range
	input wire logic [7:0] inputOpen, // Input open-circuit seen
	input wire logic supplyAbnormal, // External supply abnormal
	input wire logic hwFault, // Internal hardware fault
	output logic [2:0] convChannel, // Channel being converted
	output logic [3:0] convMode, // Mode code of that channel
	output logic convStrobe, // Sample taken, one cycle
	output logic [7:0] chanIrq, // Interrupt request pulses
	output logic runLed, // Run indicator
	output logic errLed // Error indicator
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// mode decode
	function automatic logic chanActive(input aic_pkg::mode_t code, input logic curOnly);
		if (code == `AIC_MODE_OFF)
			return 1'b0;
		if (curOnly)
			return code <= `AIC_MODE_CO_LAST;
		return code <= `AIC_MODE_I_LAST;
	endfunction

	function automatic logic openCapable(input aic_pkg::mode_t code, input logic curOnly);
		if (curOnly)
			return code == `AIC_MODE_CO_4MA_20MA;
		return (code == `AIC_MODE_1V_5V) || (code == `AIC_MODE_4MA_20MA);
	endfunction

	function automatic logic [2:0] nextActive(input logic [2:0] cur, input logic [7:0] mask);
		logic [2:0] idx;
		nextActive = cur;
		for (int k = 7; k >= 1; k--) begin
			idx = cur + 3'(k);
			if (mask[idx])
				nextActive = idx;
		end
	endfunction

	function automatic logic [31:0] toFloat(input logic signed [15:0] v);
		logic [15:0] mag;
		logic [4:0] msb;
		logic [23:0] shifted;
		mag = v[15] ? 16'(-v) : v;
		msb = 5'h0;
		for (int k = 0; k < 16; k++) begin
			if (mag[k])
				msb = 5'(k);
		end
		shifted = {8'h0, mag} << (`AIC_FLOAT_MANT_TOP - msb);
		if (mag == 16'h0)
			return 32'h0;
		return {v[15], `AIC_FLOAT_BIAS + {3'h0, msb}, shifted[22:0]};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic runEnable, next_runEnable;
	logic [31:0] modeReg, next_modeReg;
	logic [6:0] avgLen, next_avgLen;
	logic [15:0] rangeAlarm, next_rangeAlarm;
	logic [15:0] irqEn, next_irqEn;
	logic [15:0] warnLed, next_warnLed;
	logic [15:0] statusFlags, next_statusFlags;
	aic_pkg::word_t results [0:2*`AIC_CHANNELS-1];
	logic busPending, next_busPending;
	logic busWrite, next_busWrite;
	logic [7:0] busAddr, next_busAddr;
	logic next_hreadyout;
	logic [31:0] next_hrdata;
	aic_pkg::scan_state_e scanState, next_scanState;
	logic [31:0] dwell, next_dwell;
	logic [2:0] next_convChannel;
	logic [3:0] next_convMode;
	logic next_convStrobe;
	logic [7:0] next_chanIrq;
	logic next_runLed, next_errLed;
	logic [31:0] blinkCount, next_blinkCount;
	logic blinkPhase, next_blinkPhase;
	logic [7:0] activeMask, openMask;
	logic serious, minor;
	logic avgValid;
	logic [2:0] avgChan;
	logic signed [15:0] avgValue;
	logic [31:0] avgFloat;
	logic [7:0] resultOff;

	always_comb begin
		for (int i = 0; i < `AIC_CHANNELS; i++) begin
			activeMask[i] = chanActive(modeReg[i*`AIC_MODE_W +: `AIC_MODE_W], currentOnly);
			openMask[i] = openCapable(modeReg[i*`AIC_MODE_W +: `AIC_MODE_W], currentOnly);
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave and registers
	// ------------------------------------------------------------
	// One wait state on every transfer so hrdata leaves a flip-flop
	always_comb begin
		next_busPending = 1'b0;
		next_busWrite = busWrite;
		next_busAddr = busAddr;
		next_hreadyout = 1'b1;
		next_hrdata = hrdata;
		next_runEnable = runEnable;
		next_modeReg = modeReg;
		next_avgLen = avgLen;
		next_rangeAlarm = rangeAlarm;
		next_irqEn = irqEn;
		next_warnLed = warnLed;
		// Rebase so the first result word is index zero
		resultOff = busAddr - `AIC_REG_RESULT_BASE;
		if (busPending) begin
			if (busWrite) begin
				if (busAddr == `AIC_REG_CTRL)
					next_runEnable = hwdata[`AIC_CTRL_RUN_BIT];
				if (!cpuRunning) begin
					case (busAddr)
						`AIC_REG_MODE_LO: next_modeReg[15:0] = hwdata[15:0];
						`AIC_REG_MODE_HI: next_modeReg[31:16] = hwdata[15:0];
						`AIC_REG_AVG_LEN: next_avgLen = hwdata[6:0];
						`AIC_REG_RANGE_ALARM: next_rangeAlarm = hwdata[15:0];
						`AIC_REG_IRQ_EN: next_irqEn = {8'h0, hwdata[7:0]};
						`AIC_REG_WARN_LED: next_warnLed = {8'h0, hwdata[7:0]};
						default: next_avgLen = avgLen;
					endcase
				end
			end else begin
				case (busAddr)
					`AIC_REG_CTRL: next_hrdata = {31'h0, runEnable};
					`AIC_REG_MODE_LO: next_hrdata = {16'h0, modeReg[15:0]};
					`AIC_REG_MODE_HI: next_hrdata = {16'h0, modeReg[31:16]};
					`AIC_REG_AVG_LEN: next_hrdata = {25'h0, avgLen};
					`AIC_REG_RANGE_ALARM: next_hrdata = {16'h0, rangeAlarm};
					`AIC_REG_IRQ_EN: next_hrdata = {16'h0, irqEn};
					`AIC_REG_WARN_LED: next_hrdata = {16'h0, warnLed};
					`AIC_REG_STATUS: next_hrdata = {16'h0, statusFlags};
					default: next_hrdata = 32'h0;
				endcase
				if (busAddr >= `AIC_REG_RESULT_BASE && busAddr < `AIC_REG_RESULT_END)
					next_hrdata = {16'h0, results[resultOff[5:2]]};
			end
		end else if (hsel && hready && htrans[1]) begin
			next_busPending = 1'b1;
			next_busWrite = hwrite;
			next_busAddr = haddr[7:0];
			next_hreadyout = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			busPending <= 1'b0;
			busWrite <= 1'b0;
			busAddr <= 8'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			runEnable <= 1'b0;
			modeReg <= `AIC_RST_MODES;
			avgLen <= `AIC_RST_AVG_LEN;
			rangeAlarm <= `AIC_RST_WORD16;
			irqEn <= `AIC_RST_WORD16;
			warnLed <= `AIC_RST_WORD16;
			for (int i = 0; i < 2*`AIC_CHANNELS; i++)
				results[i] <= `AIC_RST_WORD16;
		end else begin
			busPending <= next_busPending;
			busWrite <= next_busWrite;
			busAddr <= next_busAddr;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			hrdata <= next_hrdata;
			runEnable <= next_runEnable;
			modeReg <= next_modeReg;
			avgLen <= next_avgLen;
			rangeAlarm <= next_rangeAlarm;
			irqEn <= next_irqEn;
			warnLed <= next_warnLed;
			if (avgValid) begin
				results[{avgChan, 1'b0}] <= avgFloat[15:0];
				results[{avgChan, 1'b1}] <= avgFloat[31:16];
			end
		end
	end

	// ------------------------------------------------------------
	// Channel scan
	// ------------------------------------------------------------
	// dwell per channel
	always_comb begin
		next_scanState = scanState;
		next_dwell = dwell;
		next_convChannel = convChannel;
		next_convStrobe = 1'b0;
		case (scanState)
			aic_pkg::SCAN_IDLE: begin
				if (runEnable && (|activeMask)) begin
					next_convChannel = nextActive(3'h7, activeMask);
					next_dwell = 32'h0;
					next_scanState = aic_pkg::SCAN_DWELL;
				end
			end
			aic_pkg::SCAN_DWELL: begin
				if (!runEnable || !activeMask[convChannel])
					next_scanState = aic_pkg::SCAN_IDLE;
				else if (dwell == 32'(CONV_CYCLES - 1)) begin
					next_convStrobe = 1'b1;
					next_scanState = aic_pkg::SCAN_STORE;
				end else
					next_dwell = dwell + 32'h1;
			end
			aic_pkg::SCAN_STORE: begin
				if (avgValid) begin
					next_convChannel = nextActive(convChannel, activeMask);
					next_dwell = 32'h0;
					next_scanState = (runEnable && (|activeMask)) ?
						aic_pkg::SCAN_DWELL : aic_pkg::SCAN_IDLE;
				end
			end
			default: next_scanState = aic_pkg::SCAN_IDLE;
		endcase
		next_convMode = modeReg[next_convChannel*`AIC_MODE_W +: `AIC_MODE_W];
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			scanState <= aic_pkg::SCAN_IDLE;
			dwell <= 32'h0;
			convChannel <= 3'h0;
			convMode <= `AIC_MODE_OFF;
			convStrobe <= 1'b0;
		end else begin
			scanState <= next_scanState;
			dwell <= next_dwell;
			convChannel <= next_convChannel;
			convMode <= next_convMode;
			convStrobe <= next_convStrobe;
		end
	end

	channel_averager averager (
		.mclk(mclk),
		.reset(reset),
		.sampleValid(convStrobe),
		.sampleChan(convChannel),
		.sample(adcData),
		.winLen(avgLen),
		.avgValid(avgValid),
		.avgChan(avgChan),
		.avg(avgValue)
	);

	assign avgFloat = toFloat(avgValue);

	// ------------------------------------------------------------
	// Status flags, requests and indicators
	// ------------------------------------------------------------
	always_comb begin
		// gated live range flags, clear on return
		for (int i = 0; i < `AIC_CHANNELS; i++)
			next_statusFlags[i] = activeMask[i] && rangeAlarm[`AIC_DETECT_LSB + i] &&
				(rangeExceeded[i] || (inputOpen[i] && openMask[i]));
		next_statusFlags[14:8] = 7'h0;
		next_statusFlags[`AIC_SUPPLY_BIT] = supplyAbnormal;
		next_chanIrq = next_statusFlags[7:0] & ~statusFlags[7:0] & irqEn[7:0];
		serious = hwFault || statusFlags[`AIC_SUPPLY_BIT] ||
			(|(statusFlags[7:0] & rangeAlarm[`AIC_ALARM_LSB +: 8]));
		minor = |(statusFlags[7:0] & ~rangeAlarm[`AIC_ALARM_LSB +: 8] & warnLed[7:0]);
		next_errLed = serious ? 1'b1 : (minor ? blinkPhase : 1'b0);
		next_runLed = runEnable && !serious;
		if (blinkCount == 32'(BLINK_CYCLES - 1)) begin
			next_blinkCount = 32'h0;
			next_blinkPhase = !blinkPhase;
		end else begin
			next_blinkCount = blinkCount + 32'h1;
			next_blinkPhase = blinkPhase;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			statusFlags <= `AIC_RST_WORD16;
			chanIrq <= 8'h0;
			errLed <= 1'b0;
			runLed <= 1'b0;
			blinkCount <= 32'h0;
			blinkPhase <= 1'b0;
		end else begin
			statusFlags <= next_statusFlags;
			chanIrq <= next_chanIrq;
			errLed <= next_errLed;
			runLed <= next_runLed;
			blinkCount <= next_blinkCount;
			blinkPhase <= next_blinkPhase;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [31:0] strobeGap;
	always_ff @(posedge mclk) begin
		if (reset || convStrobe)
			strobeGap <= 32'h1;
		else if (strobeGap != 32'hffff_ffff)
			strobeGap <= strobeGap + 32'h1;
	end

	chk_disabled_quiet:
	assert property (@(posedge mclk) disable iff (reset)
		(modeReg[3:0] == `AIC_MODE_OFF) |=> !statusFlags[0])
		else $error("disabled channel shows out-of-range");
	chk_detect_gate:
	assert property (@(posedge mclk) disable iff (reset) !rangeAlarm[0] |=> !statusFlags[0])
		else $error("range flag set with detection disabled");
	chk_alarm_error:
	assert property (@(posedge mclk) disable iff (reset)
		(statusFlags[0] && rangeAlarm[8]) |=> (errLed && !runLed))
		else $error("alarm did not light error and stop run indicator");
	chk_irq_gate:
	assert property (@(posedge mclk) disable iff (reset)
		chanIrq[0] |-> ($past(irqEn[0]) && statusFlags[0] && !$past(statusFlags[0])))
		else $error("interrupt request without enable or new flag");
	chk_warn_flash:
	assert property (@(posedge mclk) disable iff (reset) (!serious && !minor) |=> !errLed)
		else $error("error indicator lit for unflashed warning");
	chk_range_flag:
	assert property (@(posedge mclk) disable iff (reset)
		(rangeExceeded[0] && rangeAlarm[0] && activeMask[0]) |=> statusFlags[0])
		else $error("range flag missed");
	chk_supply_flag:
	assert property (@(posedge mclk) disable iff (reset)
		statusFlags[`AIC_SUPPLY_BIT] == $past(supplyAbnormal))
		else $error("supply flag does not follow supply state");
	chk_run_led:
	assert property (@(posedge mclk) disable iff (reset) !runEnable |=> !runLed)
		else $error("run indicator on while stopped");
	chk_serious_on:
	assert property (@(posedge mclk) disable iff (reset) hwFault |=> errLed [*1])
		else $error("serious fault left error indicator dark");
	chk_dwell_gap:
	assert property (@(posedge mclk) disable iff (reset)
		convStrobe |-> (strobeGap >= 32'(CONV_CYCLES)))
		else $error("samples taken closer than one conversion time");
	chk_flag_clear:
	assert property (@(posedge mclk) disable iff (reset)
		(!rangeExceeded[0] && !inputOpen[0]) |=> !statusFlags[0])
		else $error("range flag stuck after input returned");
endmodule
`default_nettype wire

// ==== verification/adc_front_model.sv ====
// Front end stand-in: returns a steady sample for the channel under conversion.
// Assumes the block holds convChannel for the whole dwell.
`timescale 1ns/10ps
`default_nettype none

module adc_front_model (
	input wire logic mclk, // Core clock
	input wire logic [2:0] convChannel, // Channel under conversion
	output logic signed [15:0] adcData // Sample for that channel
);
	// ------------------------------------------------------------
	// Sample source
	// ------------------------------------------------------------
	// One level per channel, so any window length averages back to it
	always_ff @(posedge mclk) begin
		adcData <= signed'({13'h0000, convChannel} + 16'h0003);
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the analog input channel control block.
// Assumes one AHB master (this bench) and the front end model beside it.
`timescale 1ns/10ps
`default_nettype none
`include "aic_map.svh"

module tb;
	localparam int CONV = 10;
	logic mclk = 0, reset = 1, hsel = 0, hwrite = 0, cpuRunning = 0;
	logic supplyAbnormal = 0, hwFault = 0, lastErr = 0, currentOnly = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [7:0] rangeExceeded = 0, inputOpen = 0, chanIrq;
	logic hreadyout, hresp, runLed, errLed, convStrobe;
	logic [2:0] convChannel;
	logic [3:0] convMode;
	logic signed [15:0] adcData;
	int errCount = 0, totalChecks = 0, cycles = 0, irqCount = 0, toggles = 0, base;
	logic [2:0] chans[$];
	int strobeAt[$];

	always #10 mclk = ~mclk;

	analog_input_channel_control #(.CONV_CYCLES(CONV), .BLINK_CYCLES(4))
		analog_input_channel_control_i (.mclk(mclk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.currentOnly(currentOnly), .cpuRunning(cpuRunning), .adcData(adcData),
		.rangeExceeded(rangeExceeded), .inputOpen(inputOpen),
		.supplyAbnormal(supplyAbnormal), .hwFault(hwFault), .convChannel(convChannel),
		.convMode(convMode), .convStrobe(convStrobe), .chanIrq(chanIrq),
		.runLed(runLed), .errLed(errLed));

	adc_front_model adc_front_model_i (.mclk(mclk), .convChannel(convChannel),
		.adcData(adcData));

	// ------------------------------------------------------------
	// Monitors, timeout and shared tasks
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		lastErr <= errLed;
		if (chanIrq !== 8'h00) irqCount <= irqCount + 1;
		if (errLed !== lastErr) toggles <= toggles + 1;
		if (convStrobe === 1'b1) begin
			chans.push_back(convChannel);
			strobeAt.push_back(cycles);
		end
		// Tests need a few hundred cycles; far above that means a hang
		if (cycles == 20000) begin
			errCount++;
			finishTest();
		end
	end

	task automatic finishTest();
		$display("checks %0d errors %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'b00;
		hsel <= 0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h00000000, r);
		chk(r, e);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic testReset();
		rdc(`AIC_REG_RANGE_ALARM, 0);
		rdc(`AIC_REG_IRQ_EN, 0);
		rdc(`AIC_REG_WARN_LED, 0);
		rdc(`AIC_REG_STATUS, 0);
		rdc(8'h7c, 0); // past the result words
		chk(runLed, 0);
		chk(errLed, 0);
	endtask

	task automatic testRefusal();
		cpuRunning <= 1;
		wr(`AIC_REG_RANGE_ALARM, 32'h000000ff);
		chk(hresp, 0);
		rdc(`AIC_REG_RANGE_ALARM, 0);
		cpuRunning <= 0;
		wr(`AIC_REG_RANGE_ALARM, 32'h000000ff);
		rdc(`AIC_REG_RANGE_ALARM, 32'h000000ff);
	endtask

	task automatic testModes();
		wr(`AIC_REG_RANGE_ALARM, 32'h00000001);
		for (int m = 0; m < 10; m++) begin
			wr(`AIC_REG_MODE_LO, 32'(m));
			inputOpen <= 8'h01;
			rangeExceeded <= 8'h00;
			tick(3);
			rdc(`AIC_REG_STATUS, 32'(m == 5 || m == 7));
			rangeExceeded <= 8'h01;
			tick(3);
			rdc(`AIC_REG_STATUS, 32'(m > 0 && m < 9));
		end
		// Current-only variant accepts codes one to three only
		currentOnly <= 1;
		for (int m = 2; m < 5; m++) begin
			wr(`AIC_REG_MODE_LO, 32'(m));
			tick(3);
			rdc(`AIC_REG_STATUS, 32'(m < 4));
		end
		currentOnly <= 0;
		wr(`AIC_REG_MODE_LO, 32'h00000001);
		wr(`AIC_REG_RANGE_ALARM, 0);
		tick(3);
		rdc(`AIC_REG_STATUS, 0);
		wr(`AIC_REG_RANGE_ALARM, 32'h00000001);
		rangeExceeded <= 8'h00;
		inputOpen <= 8'h00;
		tick(3);
		rdc(`AIC_REG_STATUS, 0);
	endtask

	task automatic testIrq();
		wr(`AIC_REG_IRQ_EN, 32'h00000001);
		rdc(`AIC_REG_IRQ_EN, 32'h00000001);
		base = irqCount;
		rangeExceeded <= 8'h01;
		tick(5);
		chk(32'(irqCount - base), 1);
		rangeExceeded <= 8'h00;
		wr(`AIC_REG_IRQ_EN, 0);
		rangeExceeded <= 8'h01;
		tick(5);
		chk(32'(irqCount - base), 1);
		rangeExceeded <= 8'h00;
	endtask

	task automatic testLeds();
		wr(`AIC_REG_CTRL, 32'h00000001);
		tick(4);
		chk(runLed, 1);
		wr(`AIC_REG_WARN_LED, 32'h00000001);
		rangeExceeded <= 8'h01;
		tick(4);
		base = toggles;
		tick(40);
		chk(32'(toggles - base >= 8), 1);
		chk(runLed, 1);
		wr(`AIC_REG_WARN_LED, 0);
		tick(4);
		base = toggles;
		tick(20);
		chk(32'(toggles - base), 0);
		chk(errLed, 0);
		wr(`AIC_REG_RANGE_ALARM, 32'h00000101);
		tick(4);
		chk({errLed, runLed}, 32'h2);
		wr(`AIC_REG_RANGE_ALARM, 32'h00000001);
		rangeExceeded <= 8'h00;
		supplyAbnormal <= 1;
		tick(4);
		rdc(`AIC_REG_STATUS, 32'h00008000);
		chk({errLed, runLed}, 32'h2);
		supplyAbnormal <= 0;
		tick(4);
		rdc(`AIC_REG_STATUS, 0);
		hwFault <= 1;
		tick(4);
		chk({errLed, runLed}, 32'h2);
		hwFault <= 0;
		wr(`AIC_REG_CTRL, 0);
		tick(4);
		chk({errLed, runLed}, 0);
	endtask

	task automatic testScan();
		// Scan is idle here, so clearing the log cannot race a strobe
		wr(`AIC_REG_MODE_LO, 32'h00000201);
		chans.delete();
		strobeAt.delete();
		wr(`AIC_REG_CTRL, 32'h00000001);
		for (int i = 0; i < 300 && chans.size() < 3; i++) tick(1);
		chk({chans[0], chans[1], chans[2]}, {23'h0, 3'd0, 3'd2, 3'd0});
		chk(32'(strobeAt[1] - strobeAt[0]), 32'(CONV + 2));
		tick(4);
		chk({convChannel, convMode}, 32'h00000022);
		rdc(`AIC_REG_RESULT_BASE, 0);
		rdc(`AIC_REG_RESULT_BASE + 8'h04, 32'h00004040);
		rdc(`AIC_REG_RESULT_BASE + 8'h10, 0);
		rdc(`AIC_REG_RESULT_BASE + 8'h14, 32'h000040a0);
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		reset <= 0;
		tick(1);
		testReset();
		testRefusal();
		testModes();
		testIrq();
		testLeds();
		testScan();
		finishTest();
	end
endmodule
`default_nettype wire
